// >>> include/olss_pkg.sv
package olss_pkg;

  // ==========================================================================
  // Programs and parameter table layout
  // ==========================================================================
  localparam int NUM_PROGS = 10;
  localparam int DRV_PROGS = 5;
  localparam int NUM_PARAMS = 12;
  localparam int IN_W = 16;
  localparam int DIV_W = 32;

  localparam logic [3:0] P_PRIN = 4'h0;
  localparam logic [3:0] P_BAND = 4'h1;
  localparam logic [3:0] P_LIN = 4'h2;
  localparam logic [3:0] P_FLIM = 4'h3;
  localparam logic [3:0] P_SSE = 4'h4;
  localparam logic [3:0] P_G0 = 4'h5;
  localparam logic [3:0] P_VESM = 4'hb;

  // Reset value, least and greatest value of each parameter, in index order:
  // control principle, dead band, linearity, max flow, gain source,
  // base gain, gain points 1 to 5, speed range.
  localparam logic [15:0] PARAM_DEF [NUM_PARAMS] = '{
    16'h0000, 16'h0032, 16'h0000, 16'h03e8, 16'h0001, 16'h0069,
    16'h005a, 16'h004b, 16'h003c, 16'h002d, 16'h001e, 16'h01f4};
  localparam int PARAM_MIN [NUM_PARAMS] = '{
    0, 0, -10, 0, 1, 20, 20, 20, 20, 20, 20, 1};
  localparam int PARAM_MAX [NUM_PARAMS] = '{
    255, 250, 10, 1000, 3, 1200, 1200, 1200, 1200, 1200, 1200, 1000};

  localparam logic [15:0] PRIN_OPEN_LOOP = 16'h0000;
  localparam logic [15:0] SSE_FIXED = 16'h0001;
  localparam logic [15:0] SSE_POS = 16'h0002;
  localparam logic [15:0] SSE_SPEED = 16'h0003;

  // ==========================================================================
  // Scaling
  // ==========================================================================
  localparam logic [15:0] IN_FULL = 16'h03e8;
  localparam logic [15:0] POS_FULL = 16'h03e8;
  localparam logic [15:0] GAIN_MIN = 16'h0014;
  localparam logic [15:0] GAIN_MAX = 16'h04b0;
  localparam int GAIN_SCALE = 100;
  localparam int LIN_SCALE = 10;
  // Speed breakpoints at 1/16, 1/8, 1/4, 1/2 and 1/1 of the speed range.
  localparam int BP_SHIFT [5] = '{4, 3, 2, 1, 0};

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EDIT = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FLOW = 8'h0c;
  localparam logic [7:0] REG_PARAM_BASE = 8'h40;
  localparam logic [7:0] REG_PARAM_END = 8'h70;
  localparam int CTRL_POS_MAP_BIT = 8;
  localparam int CTRL_SPD_MAP_BIT = 9;
  localparam int STAT_ACTIVE_BIT = 4;
  localparam logic [3:0] ACTIVE_PROG_RST = 4'h0;
  localparam logic [3:0] EDIT_PROG_RST = 4'h0;

  // Worst-case cycles from the start of a pass to its result.
  localparam int PASS_MAX_CYCLES = 2 * DIV_W + 8;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_GAIN_WAIT = 5'b00010,
    ST_LIN_START = 5'b00100,
    ST_LIN_WAIT = 5'b01000,
    ST_OUT = 5'b10000
  } olss_state_e;

endpackage

// >>> rtl/olss_divider.sv
module olss_divider #(
  parameter int W = 32
) (
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic start, // Starts a division.
  input wire logic [W-1:0] dividend, // Numerator, taken with start.
  input wire logic [W-1:0] divisor, // Denominator, non-zero.
  output logic busy, // Division in progress.
  output logic done, // One-cycle pulse with the quotient.
  output logic [W-1:0] quotient // Quotient, valid from done.
);

  // ==========================================================================
  // Restoring divider, one quotient bit per cycle
  // ==========================================================================
  logic [W:0] rem, next_rem;
  logic [W-1:0] quot, next_quot, den, next_den;
  logic [$clog2(W+1)-1:0] cnt, next_cnt;
  logic next_busy, next_done;
  logic [W:0] trial;

  always_comb begin
    next_rem = rem;
    next_quot = quot;
    next_den = den;
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    trial = {rem[W-1:0], quot[W-1]};
    if (start && !busy) begin
      next_rem = '0;
      next_quot = dividend;
      next_den = divisor;
      next_cnt = ($clog2(W+1))'(W);
      next_busy = 1'b1;
    end else if (busy) begin
      if (trial >= {1'b0, den}) begin
        next_rem = trial - {1'b0, den};
        next_quot = {quot[W-2:0], 1'b1};
      end else begin
        next_rem = trial;
        next_quot = {quot[W-2:0], 1'b0};
      end
      next_cnt = cnt - 1'b1;
      if (cnt == 1) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rem <= '0;
      quot <= '0;
      den <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      rem <= next_rem;
      quot <= next_quot;
      den <= next_den;
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign quotient = quot;

endmodule // olss_divider

// >>> rtl/olss_top.sv
module olss_top (
  input wire logic hclk, // Clock, 100 MHz.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic [31:0] hrdata, // AHB read data.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  input wire logic signed [15:0] steer_in, // Steering input, -1000 to 1000.
  input wire logic signed [15:0] pos_in, // Actuator position, 1000 at full lock.
  input wire logic signed [15:0] vehicle_speed, // Speed in 0.1 km/h.
  input wire logic drv_sel, // Driver program select strobe.
  input wire logic [2:0] drv_prog, // Driver program, 0 to 4.
  output logic signed [15:0] flow_setpoint, // Requested port flow.
  output logic flow_valid, // Pulse when flow_setpoint is updated.
  output logic open_loop_active // Active program is in open loop.
);

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  logic wr_pend, next_wr_pend, rd_pend, next_rd_pend, hit_r, next_hit;
  logic [7:0] addr_r, next_addr;
  logic [31:0] next_hrdata, rd_mux;
  logic next_hreadyout;
  logic [3:0] active_prog, next_active_prog, edit_prog, next_edit_prog;
  logic pos_mapped, next_pos_mapped, spd_mapped, next_spd_mapped;
  logic [15:0] prm [olss_pkg::NUM_PROGS][olss_pkg::NUM_PARAMS];
  logic [15:0] next_prm [olss_pkg::NUM_PROGS][olss_pkg::NUM_PARAMS];
  logic param_hit;
  logic [3:0] param_idx;

  assign param_hit = addr_r >= olss_pkg::REG_PARAM_BASE && addr_r < olss_pkg::REG_PARAM_END
    && addr_r[1:0] == 2'b00;
  assign param_idx = 4'((addr_r - olss_pkg::REG_PARAM_BASE) >> 2);

  function automatic logic [15:0] clamp_param(input logic [3:0] k, input logic [31:0] w);
    int v;
    v = int'($signed(w[15:0]));
    if (v < olss_pkg::PARAM_MIN[k]) v = olss_pkg::PARAM_MIN[k];
    else if (v > olss_pkg::PARAM_MAX[k]) v = olss_pkg::PARAM_MAX[k];
    return 16'(v);
  endfunction

  always_comb begin
    next_wr_pend = 1'b0;
    next_rd_pend = 1'b0;
    next_addr = addr_r;
    next_hit = hit_r;
    next_hreadyout = 1'b1;
    next_hrdata = hrdata;
    if (rd_pend) begin
      next_hrdata = rd_mux;
    end
    if (hsel && hready && htrans[1]) begin
      next_addr = haddr[7:0];
      next_hit = haddr[31:8] == 24'h000000;
      next_wr_pend = hwrite;
      next_rd_pend = !hwrite;
      next_hreadyout = hwrite;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    if (!hit_r) begin
      rd_mux = 32'h00000000;
    end else if (addr_r == olss_pkg::REG_CTRL) begin
      rd_mux[3:0] = active_prog;
      rd_mux[olss_pkg::CTRL_POS_MAP_BIT] = pos_mapped;
      rd_mux[olss_pkg::CTRL_SPD_MAP_BIT] = spd_mapped;
    end else if (addr_r == olss_pkg::REG_EDIT) begin
      rd_mux[3:0] = edit_prog;
    end else if (addr_r == olss_pkg::REG_STATUS) begin
      rd_mux[3:0] = active_prog;
      rd_mux[olss_pkg::STAT_ACTIVE_BIT] = open_loop_active;
    end else if (addr_r == olss_pkg::REG_FLOW) begin
      rd_mux = {{16{flow_setpoint[15]}}, flow_setpoint};
    end else if (param_hit) begin
      rd_mux = {{16{prm[edit_prog][param_idx][15]}}, prm[edit_prog][param_idx]};
    end
  end

  always_comb begin
    next_active_prog = active_prog;
    next_edit_prog = edit_prog;
    next_pos_mapped = pos_mapped;
    next_spd_mapped = spd_mapped;
    next_prm = prm;
    if (wr_pend && hit_r) begin
      if (addr_r == olss_pkg::REG_CTRL) begin
        if (hwdata[3:0] < 4'(olss_pkg::NUM_PROGS)) begin
          next_active_prog = hwdata[3:0];
        end
        next_pos_mapped = hwdata[olss_pkg::CTRL_POS_MAP_BIT];
        next_spd_mapped = hwdata[olss_pkg::CTRL_SPD_MAP_BIT];
      end else if (addr_r == olss_pkg::REG_EDIT) begin
        if (hwdata[3:0] < 4'(olss_pkg::NUM_PROGS)) begin
          next_edit_prog = hwdata[3:0];
        end
      end else if (param_hit) begin
        next_prm[edit_prog][param_idx] = clamp_param(param_idx, hwdata);
      end
    end
    if (drv_sel && drv_prog < 3'(olss_pkg::DRV_PROGS)) begin
      next_active_prog = {1'b0, drv_prog};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_r <= 8'h00;
      hit_r <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
      active_prog <= olss_pkg::ACTIVE_PROG_RST;
      edit_prog <= olss_pkg::EDIT_PROG_RST;
      pos_mapped <= 1'b0;
      spd_mapped <= 1'b0;
      for (int i = 0; i < olss_pkg::NUM_PROGS; i++) begin
        for (int k = 0; k < olss_pkg::NUM_PARAMS; k++) begin
          prm[i][k] <= olss_pkg::PARAM_DEF[k];
        end
      end
    end else if (ce) begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      addr_r <= next_addr;
      hit_r <= next_hit;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
      active_prog <= next_active_prog;
      edit_prog <= next_edit_prog;
      pos_mapped <= next_pos_mapped;
      spd_mapped <= next_spd_mapped;
      prm <= next_prm;
    end
  end

  // ==========================================================================
  // Gain source and table segment
  // ==========================================================================
  logic [15:0] control_principle_sel, centre_dead_band, max_flow_limit, sse, vesm;
  logic [15:0] x_abs, g_lo, g_hi, x_off, x_span, g_diff;
  logic signed [15:0] lin;
  logic [15:0] gtab [6];
  logic [15:0] bp [6];
  logic need_interp;

  assign control_principle_sel = prm[active_prog][olss_pkg::P_PRIN];
  assign centre_dead_band = prm[active_prog][olss_pkg::P_BAND];
  assign lin = $signed(prm[active_prog][olss_pkg::P_LIN]);
  assign max_flow_limit = prm[active_prog][olss_pkg::P_FLIM];
  assign sse = prm[active_prog][olss_pkg::P_SSE];
  assign vesm = prm[active_prog][olss_pkg::P_VESM];

  always_comb begin
    for (int k = 0; k < 6; k++) begin
      gtab[k] = prm[active_prog][olss_pkg::P_G0 + 4'(k)];
    end
    x_abs = 16'h0000;
    g_lo = gtab[0];
    g_hi = gtab[0];
    x_off = 16'h0000;
    x_span = 16'h0001;
    bp[0] = 16'h0000;
    for (int k = 1; k < 6; k++) begin
      bp[k] = vesm >> olss_pkg::BP_SHIFT[k-1];
    end
    if (sse == olss_pkg::SSE_POS) begin
      if (pos_mapped) begin
        x_abs = pos_in[15] ? 16'(-pos_in) : pos_in;
      end
      if (x_abs > olss_pkg::POS_FULL) begin
        x_abs = olss_pkg::POS_FULL;
      end
      g_hi = gtab[1];
      x_off = x_abs;
      x_span = olss_pkg::POS_FULL;
    end else if (sse == olss_pkg::SSE_SPEED) begin
      if (spd_mapped) begin
        x_abs = vehicle_speed[15] ? 16'(-vehicle_speed) : vehicle_speed;
      end
      if (x_abs >= vesm) begin
        g_lo = gtab[5];
        g_hi = gtab[5];
      end else begin
        for (int k = 0; k < 5; k++) begin
          if (x_abs >= bp[k]) begin
            g_lo = gtab[k];
            g_hi = gtab[k+1];
            x_off = x_abs - bp[k];
            x_span = bp[k+1] - bp[k];
          end
        end
      end
    end
  end

  assign g_diff = (g_lo >= g_hi) ? g_lo - g_hi : g_hi - g_lo;
  assign need_interp = g_diff != 16'h0000 && x_off != 16'h0000;

  // ==========================================================================
  // Set-point pipeline
  // ==========================================================================
  olss_pkg::olss_state_e state, next_state;
  logic [15:0] gain_r, next_gain, g_lo_r, next_g_lo, d_r, next_d, s_r, next_s;
  logic [15:0] flim_r, next_flim, shaped_r, next_shaped, mag;
  logic signed [15:0] lin_r, next_lin, next_flow;
  logic falling_r, next_falling, neg_r, next_neg, next_valid, next_active;
  logic div_start, div_done;
  logic [31:0] div_num, div_den, div_q;
  int flow_i;

  assign mag = steer_in[15] ? 16'(-steer_in) : steer_in;

  olss_divider #(.W(olss_pkg::DIV_W)) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(div_start),
    .dividend(div_num),
    .divisor(div_den),
    .busy(),
    .done(div_done),
    .quotient(div_q)
  );

  always_comb begin
    next_state = state;
    next_gain = gain_r;
    next_g_lo = g_lo_r;
    next_falling = falling_r;
    next_d = d_r;
    next_s = s_r;
    next_flim = flim_r;
    next_lin = lin_r;
    next_neg = neg_r;
    next_shaped = shaped_r;
    next_flow = flow_setpoint;
    next_valid = 1'b0;
    next_active = open_loop_active;
    div_start = 1'b0;
    div_num = 32'h00000000;
    div_den = 32'h00000001;
    flow_i = 0;
    case (state)
      olss_pkg::ST_IDLE: begin
        if (control_principle_sel != olss_pkg::PRIN_OPEN_LOOP) begin
          next_flow = 16'sh0000;
          next_active = 1'b0;
          next_valid = 1'b1;
        end else begin
          next_s = olss_pkg::IN_FULL - centre_dead_band;
          next_d = (mag > olss_pkg::IN_FULL) ? olss_pkg::IN_FULL - centre_dead_band
            : (mag > centre_dead_band) ? mag - centre_dead_band : 16'h0000;
          next_neg = steer_in[15];
          next_flim = max_flow_limit;
          next_lin = lin;
          next_g_lo = g_lo;
          next_falling = g_lo >= g_hi;
          // With no offset into the segment, or equal ends, its start point is the gain.
          next_gain = g_lo;
          next_state = olss_pkg::ST_LIN_START;
          if (need_interp) begin
            div_start = 1'b1;
            div_num = 32'(g_diff) * 32'(x_off);
            div_den = 32'(x_span);
            next_state = olss_pkg::ST_GAIN_WAIT;
          end
        end
      end
      olss_pkg::ST_GAIN_WAIT: begin
        if (div_done) begin
          next_gain = falling_r ? g_lo_r - div_q[15:0] : g_lo_r + div_q[15:0];
          next_state = olss_pkg::ST_LIN_START;
        end
      end
      olss_pkg::ST_LIN_START: begin
        next_shaped = d_r;
        next_state = olss_pkg::ST_OUT;
        if (lin_r != 16'sh0000 && d_r != 16'h0000) begin
          div_start = 1'b1;
          div_num = 32'(lin_r[15] ? -lin_r : lin_r) * 32'(d_r) * 32'(s_r - d_r);
          div_den = 32'(olss_pkg::LIN_SCALE) * 32'(s_r);
          next_state = olss_pkg::ST_LIN_WAIT;
        end
      end
      olss_pkg::ST_LIN_WAIT: begin
        if (div_done) begin
          next_shaped = lin_r[15] ? d_r + div_q[15:0] : d_r - div_q[15:0];
          next_state = olss_pkg::ST_OUT;
        end
      end
      olss_pkg::ST_OUT: begin
        flow_i = int'(shaped_r) * int'(gain_r) / olss_pkg::GAIN_SCALE;
        if (flow_i > int'(flim_r)) begin
          flow_i = int'(flim_r);
        end
        next_flow = neg_r ? 16'(-flow_i) : 16'(flow_i);
        next_valid = 1'b1;
        next_active = 1'b1;
        next_state = olss_pkg::ST_IDLE;
      end
      default: begin
        next_state = olss_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= olss_pkg::ST_IDLE;
      gain_r <= 16'h0000;
      g_lo_r <= 16'h0000;
      falling_r <= 1'b0;
      d_r <= 16'h0000;
      s_r <= 16'h0000;
      flim_r <= 16'h0000;
      lin_r <= 16'sh0000;
      neg_r <= 1'b0;
      shaped_r <= 16'h0000;
      flow_setpoint <= 16'sh0000;
      flow_valid <= 1'b0;
      open_loop_active <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      gain_r <= next_gain;
      g_lo_r <= next_g_lo;
      falling_r <= next_falling;
      d_r <= next_d;
      s_r <= next_s;
      flim_r <= next_flim;
      lin_r <= next_lin;
      neg_r <= next_neg;
      shaped_r <= next_shaped;
      flow_setpoint <= next_flow;
      flow_valid <= next_valid;
      open_loop_active <= next_active;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  localparam int PASS_MAX = olss_pkg::PASS_MAX_CYCLES;
  logic idle_ol;
  logic [15:0] flow_abs;
  assign idle_ol = ce && state == olss_pkg::ST_IDLE
    && control_principle_sel == olss_pkg::PRIN_OPEN_LOOP;
  assign flow_abs = flow_setpoint[15] ? 16'(-flow_setpoint) : flow_setpoint;

  property p_closed_idle;
    @(posedge hclk) disable iff (!hresetn)
    ce && state == olss_pkg::ST_IDLE && control_principle_sel != olss_pkg::PRIN_OPEN_LOOP
      |=> flow_setpoint == 16'sh0000 && !open_loop_active && flow_valid;
  endproperty
  a_closed_idle: assert property (p_closed_idle) else $error("flow not zero when closed");
  property p_prog_range;
    @(posedge hclk) disable iff (!hresetn) active_prog < 4'(olss_pkg::NUM_PROGS);
  endproperty
  a_prog_range: assert property (p_prog_range) else $error("program index out of range");
  property p_drv_sel;
    @(posedge hclk) disable iff (!hresetn)
    ce && drv_sel && drv_prog < 3'(olss_pkg::DRV_PROGS) |=> active_prog == {1'b0, $past(drv_prog)};
  endproperty
  a_drv_sel: assert property (p_drv_sel) else $error("driver program not taken");
  property p_dead_band;
    @(posedge hclk) disable iff (!hresetn)
    ce && state == olss_pkg::ST_OUT && d_r == 16'h0000 |=> flow_setpoint == 16'sh0000 && flow_valid;
  endproperty
  a_dead_band: assert property (p_dead_band) else $error("flow inside dead band");
  property p_flow_clamp;
    @(posedge hclk) disable iff (!hresetn) flow_valid && open_loop_active |-> flow_abs <= flim_r;
  endproperty
  a_flow_clamp: assert property (p_flow_clamp) else $error("flow above max flow");
  property p_gain_range;
    @(posedge hclk) disable iff (!hresetn) state == olss_pkg::ST_LIN_START
      |-> gain_r >= olss_pkg::GAIN_MIN && gain_r <= olss_pkg::GAIN_MAX;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out of range");
  property p_fixed_gain;
    @(posedge hclk) disable iff (!hresetn)
    idle_ol && sse == olss_pkg::SSE_FIXED |=> gain_r == $past(gtab[0]);
  endproperty
  a_fixed_gain: assert property (p_fixed_gain) else $error("fixed gain not base gain");
  property p_pos_unmapped;
    @(posedge hclk) disable iff (!hresetn)
    idle_ol && sse == olss_pkg::SSE_POS && !pos_mapped |=> gain_r == $past(gtab[0]);
  endproperty
  a_pos_unmapped: assert property (p_pos_unmapped) else $error("unmapped position gain");
  property p_speed_top;
    @(posedge hclk) disable iff (!hresetn)
    idle_ol && sse == olss_pkg::SSE_SPEED && spd_mapped && x_abs >= vesm
      |=> gain_r == $past(gtab[5]) && state == olss_pkg::ST_LIN_START;
  endproperty
  a_speed_top: assert property (p_speed_top) else $error("gain above range not held");
  property p_pass_len;
    @(posedge hclk) disable iff (!hresetn)
    idle_ol |-> ##[1:PASS_MAX] flow_valid;
  endproperty
  a_pass_len: assert property (p_pass_len) else $error("pass did not finish");

  c_flow: cover property (@(posedge hclk) flow_valid && open_loop_active && flow_setpoint != 16'sh0000);
  c_interp: cover property (@(posedge hclk) state == olss_pkg::ST_GAIN_WAIT && div_done);
  c_shape: cover property (@(posedge hclk) state == olss_pkg::ST_LIN_WAIT && div_done);
  c_drv: cover property (@(posedge hclk) drv_sel && drv_prog == 3'h4);

endmodule // olss_top

// >>> testbench/olss_steer_dev.sv
module olss_steer_dev (
  input wire logic hclk, // Clock.
  input wire logic signed [15:0] lever, // Lever deflection.
  output logic signed [15:0] steer_in // Sensor output.
);
  timeunit 1ns;
  timeprecision 1ps;
  // The sensor reports the lever one sample late.
  always @(posedge hclk) begin
    steer_in <= lever;
  end
endmodule // olss_steer_dev

// >>> testbench/olss_top_tb_top.sv
module olss_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic ce = 1'b1;
  logic hresp;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic signed [15:0] lever = 16'sh0;
  logic signed [15:0] pos_in = 16'sh0;
  logic signed [15:0] vehicle_speed = 16'sh0;
  logic drv_sel = 1'b0;
  logic [2:0] drv_prog = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic signed [15:0] steer_in;
  logic signed [15:0] flow_setpoint;
  logic flow_valid;
  logic open_loop_active;
  logic [31:0] seed = 32'h4f;
  int errors = 0;
  int checks = 0;
  olss_steer_dev i_dev (.hclk(hclk), .lever(lever), .steer_in(steer_in));
  olss_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .steer_in(steer_in), .pos_in(pos_in),
    .vehicle_speed(vehicle_speed), .drv_sel(drv_sel), .drv_prog(drv_prog),
    .flow_setpoint(flow_setpoint), .flow_valid(flow_valid), .open_loop_active(open_loop_active));
  initial begin
    forever #5 hclk = ~hclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int ef(int s, int band, int g, int lim, int ln);
    int d;
    int sp;
    d = (s < 0) ? -s : s;
    d = (d > 1000) ? 1000 : d;
    sp = 1000 - band;
    d = (d > band) ? d - band : 0;
    d = d - ln * d * (sp - d) / (10 * sp);
    d = d * g / 100;
    d = (d > lim) ? lim : d;
    return (s < 0) ? -d : d;
  endfunction
  function automatic int gi(int lo, int hi, int x, int span);
    return (lo >= hi) ? lo - (lo - hi) * x / span : lo + (hi - lo) * x / span;
  endfunction
  task automatic finish_test();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    checks++;
    if (got !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wait_on(input logic fl);
    int n;
    n = 0;
    @(posedge hclk);
    while ((fl ? flow_valid : hreadyout) !== 1'b1) begin
      n++;
      if (n > 200) begin
        errors++;
        finish_test();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input int d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_on(1'b0);
    htrans <= 2'h0;
    hwdata <= 32'(d);
    wait_on(1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input int e);
    bus(1'b0, a, 0);
    chk($sformatf("reg %h", a), 32'(e), hrdata);
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic flow(input int s, input int e);
    lever <= 16'(s);
    repeat (3) wait_on(1'b1);
    chk("flow", 32'(e), 32'(flow_setpoint));
  endtask
  initial begin
    int s;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < 12; k++) begin
      rd(8'h40 + 8'(4 * k), int'(signed'(olss_pkg::PARAM_DEF[k])));
    end
    rd(8'h20, 0);
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 50 : (i == 1) ? -1000 : int'(rnd() % 32'd2001) - 1000;
      flow(s, ef(s, 50, 105, 1000, 0));
    end
    flow(700, ef(700, 50, 105, 1000, 0));
    ce <= 1'b0;
    lever <= 16'sd900;
    repeat (20) @(posedge hclk);
    chk("frozen", 32'(ef(700, 50, 105, 1000, 0)), 32'(flow_setpoint));
    ce <= 1'b1;
    bus(1'b1, 8'h48, 10);
    flow(500, ef(500, 50, 105, 1000, 10));
    bus(1'b1, 8'h48, -10);
    flow(-700, ef(-700, 50, 105, 1000, -10));
    bus(1'b1, 8'h48, 0);
    bus(1'b1, 8'h4c, 500);
    bus(1'b1, 8'h44, 300);
    rd(8'h44, 250);
    flow(-1000, ef(-1000, 250, 105, 500, 0));
    rd(8'h0c, ef(-1000, 250, 105, 500, 0));
    bus(1'b1, 8'h4c, 1000);
    bus(1'b1, 8'h50, 2);
    bus(1'b1, 8'h00, 32'h100);
    pos_in <= -16'sd500;
    flow(1000, ef(1000, 250, gi(105, 90, 500, 1000), 1000, 0));
    pos_in <= -16'sd1000;
    flow(1000, ef(1000, 250, 90, 1000, 0));
    bus(1'b1, 8'h00, 0);
    flow(1000, ef(1000, 250, 105, 1000, 0));
    bus(1'b1, 8'h50, 3);
    bus(1'b1, 8'h00, 32'h200);
    vehicle_speed <= -16'sd2000;
    flow(600, ef(600, 250, 30, 1000, 0));
    vehicle_speed <= 16'sd250;
    flow(600, ef(600, 250, 45, 1000, 0));
    vehicle_speed <= 16'sd100;
    flow(600, ef(600, 250, gi(75, 60, 100 - 500 / 8, 500 / 4 - 500 / 8), 1000, 0));
    bus(1'b1, 8'h54, 100000 / 750);
    bus(1'b1, 8'h00, 0);
    flow(600, ef(600, 250, 100000 / 750, 1000, 0));
    chk("active", 32'h1, 32'(open_loop_active));
    bus(1'b1, 8'h40, 5);
    repeat (2) wait_on(1'b1);
    chk("active", 32'h0, 32'(open_loop_active));
    chk("flow", 32'h0, 32'(flow_setpoint));
    drv_prog <= 3'h3;
    drv_sel <= 1'b1;
    @(posedge hclk);
    drv_prog <= 3'h6;
    @(posedge hclk);
    drv_sel <= 1'b0;
    bus(1'b1, 8'h00, 12);
    rd(8'h00, 3);
    bus(1'b1, 8'h04, 3);
    rd(8'h44, 50);
    rd(8'h08, 32'h13);
    finish_test();
  end
endmodule // olss_top_tb_top
